// File: fhb_host_bus.sv
`timescale 1ns/10ps
// Function
// - Raise interrupt for each data byte in programmed I/O mode.
// - Raise interrupt when read/write command ends, for result reading.
// - Raise interrupt when seek or track-zero return finishes.
// - Raise interrupt when a drive ready level changed since last poll.
// - Style select low gives strobe bus with read/write strobes.
// - Style select high gives phase-clock bus with direction signal.
// - Strobe mode: accesses timed by strobes, qualified by select.
// - Strobe mode: write data captured on write strobe rising edge.
// - DMA grant strobe selects data port without address.
// - DMA grant acts as chip select; host stretches cycles.
// - Phase-clock mode: accesses synchronised to bus phase clock.
// - Phase-clock mode: sample direction/select on phase clock rise.
// - Phase-clock mode: DMA grant timed exactly like chip select.
// - Drive data rate follows clock and density, and media size input at 16 MHz only.
module fhb_host_bus
  import fhb_pkg::*;
(
  input  wire logic       clk,               // System clock, 100 MHz
  input  wire logic       rst,               // Synchronous reset
  input  wire logic       bus_style_select,  // 0 strobe bus, 1 phase bus
  input  wire logic       cs_n,              // Chip select
  input  wire logic       reg_pick,          // Register select
  input  wire logic       rd_n,              // Read strobe / unused
  input  wire logic       wr_n,              // Write strobe / direction
  input  wire logic       phase_clk,         // Bus phase clock
  input  wire logic       dma_grant_strobe_n,// DMA grant strobe
  input  wire logic [7:0] data_in,           // Host data bus input
  output logic      [7:0] data_out,          // Host data bus output
  output logic            data_oe,           // Data bus output enable
  output logic            irq_n,             // Host interrupt request
  output logic            dma_req,           // DMA request
  input  wire logic       dma_mode,          // Core uses DMA transfers
  input  wire logic       core_byte_req,     // Core wants a data byte
  input  wire logic [7:0] core_rd_data,      // Byte from the disk side
  output logic      [7:0] core_wr_data,      // Byte written by host
  output logic            core_byte_done,    // Data byte moved, pulse
  input  wire logic       core_cmd_end,      // Read/write command ended
  input  wire logic       core_result_done,  // Results all read, pulse
  input  wire logic       core_seek_end,     // Seek/track-zero finished
  input  wire logic       core_sense_cmd,    // Sense-event issued, pulse
  input  wire logic [1:0] unit_pick,         // Drive being polled
  input  wire logic       core_poll,         // Poll strobe for that drive
  input  wire logic       drive_ready,       // Ready input of drive
  output logic            unit_pick_bit0,    // Unit select bit 0
  output logic            unit_pick_bit1,    // Unit select bit 1
  input  wire logic       media_size,        // Media size select input
  input  wire logic       mfm_mode,          // 1 double, 0 single density
  input  wire logic       clk_is_19m,        // Drive clock is 19.2 MHz
  output logic      [2:0] data_rate_code     // Selected serial rate
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [6:0] sync1_ff;
  logic [6:0] sync2_ff;
  logic [6:0] nxt_sync1;
  logic [6:0] nxt_sync2;
  logic       style_s;
  logic       cs_s;
  logic       pick_s;
  logic       rd_s;
  logic       wr_s;
  logic       phase_s;
  logic       grant_s;
  logic [7:0] din1_ff;
  logic [7:0] din2_ff;
  logic       rdy1_ff;
  logic       rdy2_ff;

  always_comb begin
    // Data and strobes share one depth, so they stay lined up in time
    nxt_sync1 = {bus_style_select, cs_n, reg_pick, rd_n, wr_n,
                 phase_clk, dma_grant_strobe_n};
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      // Idle pin levels, so no false edge is seen after reset
      sync1_ff <= 7'h2d;
      sync2_ff <= 7'h2d;
      din1_ff  <= 8'h00;
      din2_ff  <= 8'h00;
      rdy1_ff  <= 1'b0;
      rdy2_ff  <= 1'b0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      din1_ff  <= data_in;
      din2_ff  <= din1_ff;
      rdy1_ff  <= drive_ready;
      rdy2_ff  <= rdy1_ff;
    end
  end

  assign {style_s, cs_s, pick_s, rd_s, wr_s, phase_s, grant_s} = sync2_ff;

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  logic        wr_prev_ff;
  logic        rd_prev_ff;
  logic        phase_prev_ff;
  logic        sel_status;
  logic        sel_data;
  logic        rd_active;
  logic        wr_rise;
  logic        phase_rise;
  fhb_acc_type acc;

  always_comb begin
    // Grant needs no address and always hits the data port
    // grant selects data
    sel_data   = !grant_s || (!cs_s && pick_s == REG_DATA);
    sel_status = grant_s && !cs_s && pick_s == REG_STATUS;
    wr_rise    = wr_s && !wr_prev_ff;
    phase_rise = phase_s && !phase_prev_ff;
    rd_active  = 1'b0;
    acc        = FHB_ACC_IDLE;
    if (!style_s) begin
      rd_active = !rd_s && (sel_data || sel_status);
      if (wr_rise && (sel_data || sel_status))
        acc = FHB_ACC_WR;
      // A read counts once, at the trailing edge of its strobe
      else if (rd_s && !rd_prev_ff && (sel_data || sel_status))
        acc = FHB_ACC_RD;
    end else begin
      // grant like select
      // The write pin carries the direction here: high means read
      rd_active = phase_s && wr_s && (sel_data || sel_status);
      if (phase_rise && (sel_data || sel_status))
        acc = wr_s ? FHB_ACC_RD : FHB_ACC_WR;
    end
  end

  // ----------------------------------------
  // Data path and access tracking
  // ----------------------------------------
  logic [7:0] dout_ff;
  logic [7:0] nxt_dout;
  logic [7:0] wdata_ff;
  logic [7:0] nxt_wdata;
  logic       done_ff;
  logic       nxt_done;
  logic       oe_ff;
  logic [7:0] status_val;

  always_comb begin
    // Read data tracks the selects every cycle; the host samples it late
    nxt_dout  = sel_data ? core_rd_data : status_val;
    nxt_wdata = wdata_ff;
    nxt_done  = 1'b0;
    if (acc == FHB_ACC_WR && sel_data) begin
      nxt_wdata = din2_ff;
      nxt_done  = 1'b1;
    end
    if (acc == FHB_ACC_RD && sel_data)
      nxt_done = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_prev_ff    <= 1'b1;
      rd_prev_ff    <= 1'b1;
      phase_prev_ff <= 1'b0;
      dout_ff       <= STATUS_RESET;
      wdata_ff      <= 8'h00;
      done_ff       <= 1'b0;
      oe_ff         <= 1'b0;
    end else begin
      wr_prev_ff    <= wr_s;
      rd_prev_ff    <= rd_s;
      phase_prev_ff <= phase_s;
      dout_ff       <= nxt_dout;
      wdata_ff      <= nxt_wdata;
      done_ff       <= nxt_done;
      oe_ff         <= rd_active;
    end
  end

  // Output enable lags the strobe by the sync depth plus one cycle
  assign data_out       = dout_ff;
  assign data_oe        = oe_ff;
  assign core_wr_data   = wdata_ff;
  assign core_byte_done = done_ff;

  // ----------------------------------------
  // Interrupt causes
  // ----------------------------------------
  logic [3:0] cause_ff;
  logic [3:0] nxt_cause;
  logic [DRIVE_COUNT-1:0] seen_ff;
  logic [DRIVE_COUNT-1:0] nxt_seen;
  logic       rdy_diff;

  assign rdy_diff = core_poll && (seen_ff[unit_pick] != rdy2_ff);

  // Each drive keeps the ready level seen at its own last poll
  for (genvar g = 0; g < DRIVE_COUNT; g++) begin : g_seen
    assign nxt_seen[g] = (core_poll && unit_pick == 2'(g)) ? rdy2_ff
                                                           : seen_ff[g];
  end

  always_comb begin
    // Status reads clear nothing; a cause goes only when serviced
    nxt_cause = cause_ff;
    // Clears come first so a same-cycle event wins, except a PIO byte request while done_ff is set
    // hold until serviced
    if (done_ff)
      nxt_cause[CAUSE_BIT_DATA] = 1'b0;
    if (core_result_done)
      nxt_cause[CAUSE_BIT_RES] = 1'b0;
    if (core_sense_cmd) begin
      nxt_cause[CAUSE_BIT_SEEK] = 1'b0;
      nxt_cause[CAUSE_BIT_RDY]  = 1'b0;
    end
    // No re-arm while the finished byte is taken or still reported
    // PIO byte request
    if (core_byte_req && !dma_mode && !nxt_done && !done_ff)
      nxt_cause[CAUSE_BIT_DATA] = 1'b1;
    if (core_cmd_end)
      nxt_cause[CAUSE_BIT_RES] = 1'b1;
    if (core_seek_end)
      nxt_cause[CAUSE_BIT_SEEK] = 1'b1;
    if (rdy_diff)
      nxt_cause[CAUSE_BIT_RDY] = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cause_ff <= 4'h0;
      seen_ff  <= '0;
    end else begin
      cause_ff <= nxt_cause;
      seen_ff  <= nxt_seen;
    end
  end

  assign status_val = {4'h0, cause_ff};
  // Level output: it stays low while any cause is pending
  assign irq_n      = !(|cause_ff);
  assign dma_req    = core_byte_req && dma_mode;

  // ----------------------------------------
  // Drive side
  // ----------------------------------------
  logic [2:0] strap1_ff;
  logic [2:0] strap2_ff;
  logic [2:0] nxt_rate;
  logic [2:0] rate_ff;
  logic [1:0] unit_ff;

  // Straps are pins like any other, so they take the same two stages;
  // a strap change reaches the rate code three cycles late
  // The untabled 19.2 MHz case with media size high uses the 19.2 row
  // rate selection
  always_comb begin
    if (strap2_ff[2])
      nxt_rate = strap2_ff[0] ? RATE_KBPS_300 : RATE_KBPS_150;
    else if (strap2_ff[1])
      nxt_rate = strap2_ff[0] ? RATE_KBPS_500 : RATE_KBPS_250;
    else
      nxt_rate = strap2_ff[0] ? RATE_KBPS_250 : RATE_KBPS_125;
  end

  // No reset: these only track inputs, so they settle within 3 cycles
  always_ff @(posedge clk) begin
    strap1_ff <= {clk_is_19m, media_size, mfm_mode};
    strap2_ff <= strap1_ff;
    rate_ff   <= nxt_rate;
    unit_ff   <= unit_pick;
  end

  assign unit_pick_bit0 = unit_ff[0];
  assign unit_pick_bit1 = unit_ff[1];
  assign data_rate_code = rate_ff;

endmodule

// File: fhb_host_bus_asserts.sv
`timescale 1ns/10ps
module fhb_host_bus_asserts
  import fhb_pkg::*;
(
  input wire logic       clk,              // Clock
  input wire logic       rst,              // Reset
  input wire logic       irq_n,            // Interrupt
  input wire logic       dma_req,          // DMA request
  input wire logic       dma_mode,         // DMA mode
  input wire logic       core_byte_req,    // Byte wanted
  input wire logic       core_byte_done,   // Byte moved
  input wire logic       core_cmd_end,     // Command end
  input wire logic       core_result_done, // Results read
  input wire logic       core_seek_end,    // Seek end
  input wire logic       core_sense_cmd,   // Sense issued
  input wire logic [1:0] unit_pick,        // Polled unit
  input wire logic       unit_pick_bit0,   // Unit bit 0
  input wire logic       unit_pick_bit1,   // Unit bit 1
  input wire logic       media_size,       // Media size
  input wire logic       mfm_mode,         // Density
  input wire logic       clk_is_19m,       // Clock choice
  input wire logic [2:0] data_rate_code    // Rate code
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic clr;
  // Any servicing action; the line may lag it by up to two cycles
  assign clr = core_result_done | core_sense_cmd | core_byte_done;

  a_result_irq: assert property (core_cmd_end |-> ##[1:2] !irq_n)
    else $error("result interrupt missing");
  a_seek_irq: assert property (core_seek_end |-> ##[1:2] !irq_n)
    else $error("seek interrupt missing");
  a_irq_held: assert property (!irq_n && !clr && !$past(clr)
    && !$past(clr, 2) |=> !irq_n) else $error("interrupt dropped early");
  a_dma_req_level: assert property (dma_req == (core_byte_req && dma_mode))
    else $error("dma request wrong");
  a_done_pulse: assert property (core_byte_done |=> !core_byte_done)
    else $error("byte done too long");
  a_unit_bits: assert property (
    {unit_pick_bit1, unit_pick_bit0} == $past(unit_pick))
    else $error("unit bits wrong");
  a_rate_16m: assert property (!$past(clk_is_19m, 3) |->
    data_rate_code == ($past(media_size, 3)
      ? ($past(mfm_mode, 3) ? RATE_KBPS_500 : RATE_KBPS_250)
      : ($past(mfm_mode, 3) ? RATE_KBPS_250 : RATE_KBPS_125)))
    else $error("rate wrong at 16 MHz");
  a_rate_19m: assert property ($past(clk_is_19m, 3)
    && !$past(media_size, 3) |-> data_rate_code ==
    ($past(mfm_mode, 3) ? RATE_KBPS_300 : RATE_KBPS_150))
    else $error("rate wrong at 19.2 MHz");
endmodule

bind fhb_host_bus fhb_host_bus_asserts chk (.*);

// File: fhb_host_bus_test.sv
`timescale 1ns/10ps
module fhb_host_bus_test;
  import fhb_pkg::*;
  logic clk, rst, bus_style_select, cs_n, reg_pick, rd_n, wr_n, phase_clk;
  logic dma_grant_strobe_n, data_oe, irq_n, dma_req, dma_mode, drive_ready;
  logic core_byte_req, core_byte_done, core_cmd_end, core_result_done;
  logic core_seek_end, core_sense_cmd, core_poll, unit_pick_bit0;
  logic unit_pick_bit1, media_size, mfm_mode, clk_is_19m;
  logic [7:0] data_in, data_out, core_rd_data, core_wr_data, q, d;
  logic [2:0] data_rate_code, rate;
  logic [1:0] unit_pick;
  logic [3:0] cause;
  logic       last_rdy [4];
  int         failures, check_count, cycles;

  fhb_host_bus uut (.*);
  fhb_host_model host (.*);

  always #5 clk = ~clk;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic pulse(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
    tick(3);
  endtask

  task automatic status();
    check("irq_n", {7'h0, irq_n}, {7'h0, cause == 4'h0});
    fork
      host.access(bus_style_select, 1'h0, 1'h0, REG_STATUS, 8'h00, q);
      begin
        tick(8);
        check("data_oe", {7'h0, data_oe}, 8'h01);
      end
    join
    check("data_oe", {7'h0, data_oe}, 8'h00);
    check("status", {4'h0, q[3:0]}, {4'h0, cause});
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    {clk, bus_style_select, dma_mode, drive_ready, core_byte_req} = '0;
    {core_cmd_end, core_result_done, core_seek_end, core_sense_cmd} = '0;
    {core_poll, media_size, mfm_mode, clk_is_19m, core_rd_data} = '0;
    {unit_pick, cause, failures, check_count, cycles} = '0;
    rst = 1'h1;
    void'($urandom(88));
    repeat (20) @(posedge clk);
    #1 rst = 1'h0;
    tick(4);
    check("irq_n", {7'h0, irq_n}, 8'h01);
    check("data_oe", {7'h0, data_oe}, 8'h00);
    check("data_out", data_out, 8'h00);
    // Both bus styles, programmed and DMA data bytes
    for (int i = 0; i < 4; i++) begin
      {bus_style_select, dma_mode} = i[1:0];
      d = 8'($urandom);
      core_rd_data = 8'($urandom);
      core_byte_req = 1'h1;
      #1 check("dma_req", {7'h0, dma_req}, {7'h0, dma_mode});
      tick(1);
      core_byte_req = 1'h0;
      tick(2);
      cause[0] = !dma_mode;
      status();
      // Grant ignores the register pick
      host.access(bus_style_select, dma_mode, 1'h1, !dma_mode, d, q);
      check("core_wr_data", core_wr_data, d);
      cause[0] = 1'h0;
      host.access(bus_style_select, dma_mode, 1'h0, !dma_mode, d, q);
      check("data_out", q, core_rd_data);
      status();
    end
    $display("data byte test done");
    bus_style_select = 1'h0;
    pulse(core_cmd_end);
    cause[1] = 1'h1;
    status();
    pulse(core_result_done);
    cause[1] = 1'h0;
    status();
    pulse(core_seek_end);
    cause[2] = 1'h1;
    status();
    pulse(core_sense_cmd);
    cause[2] = 1'h0;
    status();
    // A reset in mid-run drops a pending cause
    pulse(core_seek_end);
    check("irq_n", {7'h0, irq_n}, 8'h00);
    rst = 1'h1;
    tick(3);
    rst = 1'h0;
    tick(4);
    check("irq_n", {7'h0, irq_n}, 8'h01);
    $display("event test done");
    // First pass only primes the last seen ready levels
    for (int n = 0; n < 16; n++) begin
      unit_pick = n[1:0];
      drive_ready = (n < 4) ? 1'h0 : 1'($urandom);
      tick(4);
      check("unit_pick", {6'h0, unit_pick_bit1, unit_pick_bit0},
            {6'h0, unit_pick});
      pulse(core_poll);
      if (n >= 4 && drive_ready != last_rdy[unit_pick]) cause[3] = 1'h1;
      last_rdy[unit_pick] = drive_ready;
      if (n >= 4) status();
      pulse(core_sense_cmd);
      cause[3] = 1'h0;
    end
    $display("ready poll test done");
    for (int r = 0; r < 8; r++) begin
      {clk_is_19m, media_size, mfm_mode} = r[2:0];
      tick(4);
      rate = clk_is_19m ? (mfm_mode ? RATE_KBPS_300 : RATE_KBPS_150)
           : media_size ? (mfm_mode ? RATE_KBPS_500 : RATE_KBPS_250)
           : (mfm_mode ? RATE_KBPS_250 : RATE_KBPS_125);
      check("data_rate_code", {5'h0, data_rate_code}, {5'h0, rate});
    end
    $display("rate test done");
    finish_test();
  end
endmodule

// File: fhb_host_model.sv
`timescale 1ns/10ps
module fhb_host_model (
  input  wire logic       clk,                // Clock
  input  wire logic [7:0] data_out,           // Read data
  output logic            cs_n,               // Chip select
  output logic            reg_pick,           // Register pick
  output logic            rd_n,               // Read strobe
  output logic            wr_n,               // Write strobe
  output logic            phase_clk,          // Phase clock
  output logic            dma_grant_strobe_n, // Grant strobe
  output logic      [7:0] data_in             // Write data
);
  initial {cs_n, rd_n, wr_n, dma_grant_strobe_n} = 4'hf;
  initial {reg_pick, phase_clk, data_in} = 10'h000;

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // strobes stretched well past the sync depth, as wait states
  task automatic access(input logic ph, input logic dma, input logic wr,
                        input logic pick, input logic [7:0] d,
                        output logic [7:0] q);
    // grant driven for a DMA cycle instead of chip select
    if (dma) dma_grant_strobe_n = 1'h0;
    else cs_n = 1'h0;
    reg_pick = pick;
    data_in = d;
    // direction level comes from the strobe kind
    if (ph) wr_n = !wr;
    else if (wr) wr_n = 1'h0;
    else rd_n = 1'h0;
    wait_clk(5);
    phase_clk = ph;
    wait_clk(5);
    q = data_out;
    phase_clk = 1'h0;
    rd_n = 1'h1;
    if (!ph) wr_n = 1'h1;
    wait_clk(5);
    {cs_n, dma_grant_strobe_n, wr_n} = 3'h7;
    // Released bus shows garbage, not the old byte
    data_in = ~d;
    wait_clk(2);
  endtask
endmodule

// File: fhb_pkg.sv
package fhb_pkg;

  // ----------------------------------------
  // Register picks and interrupt causes
  // ----------------------------------------
  localparam logic       REG_STATUS     = 1'h0;
  localparam logic       REG_DATA       = 1'h1;
  localparam logic [7:0] STATUS_RESET   = 8'h00;
  localparam int         CAUSE_BIT_DATA = 0;
  localparam int         CAUSE_BIT_RES  = 1;
  localparam int         CAUSE_BIT_SEEK = 2;
  localparam int         CAUSE_BIT_RDY  = 3;
  localparam int         DRIVE_COUNT    = 4;

  // ----------------------------------------
  // Data rate selection
  // ----------------------------------------
  localparam logic [1:0] RATE_CLK_16M  = 2'h0;
  localparam logic [1:0] RATE_CLK_19M  = 2'h1;
  localparam logic [2:0] RATE_KBPS_125 = 3'h0;
  localparam logic [2:0] RATE_KBPS_150 = 3'h1;
  localparam logic [2:0] RATE_KBPS_250 = 3'h2;
  localparam logic [2:0] RATE_KBPS_300 = 3'h3;
  localparam logic [2:0] RATE_KBPS_500 = 3'h4;

  typedef enum logic [1:0] {
    FHB_ACC_IDLE = 2'b00,
    FHB_ACC_RD   = 2'b01,
    FHB_ACC_WR   = 2'b10
  } fhb_acc_type;

endpackage
